// file: core/i2c_pkg.sv
// Shared constants for the two-wire register port and its host end
package i2c_pkg;
   localparam logic [6:0] TARGET_ADDR    = 7'h0F;
   localparam int         BYTE_BITS      = 8;
   localparam logic [2:0] LAST_BIT       = 3'h7;
   localparam logic [2:0] FIRST_BIT      = 3'h0;
   localparam logic       RW_READ        = 1'b1;
   localparam logic       RW_WRITE       = 1'b0;
   localparam int         CLK_HZ         = 50_000_000;
   localparam int         SCL_HZ         = 250_000;
   localparam int         HALF_CYC       = CLK_HZ / (2 * SCL_HZ);
   localparam logic [7:0] HALF_CNT       = 8'(HALF_CYC);
   localparam logic [7:0] CNT_ZERO       = 8'h00;
   localparam logic [7:0] CNT_ONE        = 8'h01;
   localparam logic [7:0] PTR_RESET      = 8'h00;
   localparam logic [7:0] PTR_MSB_MASK   = 8'h7F;
   localparam int         FIFO_DEPTH     = 4;

   typedef enum logic [1:0] {
      CMD_WRITE,
      CMD_READ
   } host_cmd_t;
endpackage : i2c_pkg

// file: core/i2c_link_if.sv
// Two-wire link between host and target, open-drain wired-and
`timescale 1ns/1ps
interface i2c_link_if;
   logic scl_oe_host;
   logic sda_oe_host;
   logic scl_oe_dev;
   logic sda_oe_dev;
   logic scl;
   logic sda;

   // Open drain: any enabled driver pulls low, else pulled up
   assign scl = !(scl_oe_host || scl_oe_dev);
   assign sda = !(sda_oe_host || sda_oe_dev);

   modport device (
      input  scl,
      input  sda,
      output scl_oe_dev,
      output sda_oe_dev
   );
   modport host (
      input  scl,
      input  sda,
      output scl_oe_host,
      output sda_oe_host
   );
endinterface : i2c_link_if

// file: core/byte_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // Fill side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             in_ready,
   // Drain side
   output      logic             out_valid,
   output      logic [WIDTH-1:0] out_data,
   input  wire logic             out_ready,
   // Flush
   input  wire logic             flush
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               rd;
      logic [AW-1:0]               wr;
      logic [AW:0]                 cnt;
   } fifo_st_t;

   fifo_st_t st_ff;
   fifo_st_t nxt_st;
   logic     push;
   logic     pop;

   assign in_ready  = (st_ff.cnt != (AW+1)'(DEPTH));
   assign out_valid = (st_ff.cnt != '0);
   assign out_data  = st_ff.mem[st_ff.rd];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      nxt_st = st_ff;
      if (flush) begin
         nxt_st.rd  = '0;
         nxt_st.wr  = '0;
         nxt_st.cnt = '0;
      end else begin
         if (push) begin
            nxt_st.mem[st_ff.wr] = in_data;
            nxt_st.wr = (st_ff.wr == AW'(DEPTH-1)) ? '0 : st_ff.wr + 1'b1;
         end
         if (pop) begin
            nxt_st.rd = (st_ff.rd == AW'(DEPTH-1)) ? '0 : st_ff.rd + 1'b1;
         end
         nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule : byte_fifo

// file: core/i2c_target_port.sv
// Target end of the two-wire register port
`timescale 1ns/1ps
module i2c_target_port (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Link
   i2c_link_if.device      link,
   // Register side
   output      logic [7:0] reg_addr,
   output      logic [7:0] reg_wdata,
   output      logic       reg_write,
   input  wire logic [7:0] reg_rdata,
   // Write data accepted by the register side
   input  wire logic       reg_ready,
   // Bus state
   output      logic       bus_busy
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ACK_ADDR,
      ST_RX,
      ST_ACK_RX,
      ST_TX,
      ST_ACK_TX,
      ST_IGNORE
   } tgt_state_t;

   typedef struct packed {
      logic [1:0] scl_sync;
      logic [1:0] sda_sync;
      logic       scl_d;
      logic       sda_d;
      tgt_state_t state;
      logic [2:0] bit_idx;
      logic [7:0] shreg;
      logic       got_ptr;
      logic       reading;
      logic [7:0] ptr;
      logic       sda_oe;
      logic       scl_oe;
      logic       busy;
      logic [7:0] wdata;
      logic       wr_pulse;
      logic       pend;
      logic       got8;
      logic [7:0] wr_addr;
      logic [7:0] wr_data;
   } tgt_st_t;

   tgt_st_t st_ff;
   tgt_st_t nxt_st;
   logic    scl_s;
   logic    sda_s;
   logic    scl_rise;
   logic    scl_fall;
   logic    start_det;
   logic    stop_det;
   logic    fifo_in_ready;
   logic    fifo_out_valid;
   logic [15:0] fifo_out_word;

   assign scl_s     = st_ff.scl_sync[1];
   assign sda_s     = st_ff.sda_sync[1];
   assign scl_rise  = scl_s && !st_ff.scl_d;
   assign scl_fall  = !scl_s && st_ff.scl_d;
   assign start_det = scl_s && st_ff.scl_d && st_ff.sda_d && !sda_s;
   assign stop_det  = scl_s && st_ff.scl_d && !st_ff.sda_d && sda_s;

   // Received data bytes queue here with their pointer; a full queue stretches the clock
   byte_fifo #(
      .WIDTH (16),
      .DEPTH (i2c_pkg::FIFO_DEPTH)
   ) u_wfifo (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_valid  (st_ff.pend),
      .in_data   ({st_ff.ptr, st_ff.wdata}),
      .in_ready  (fifo_in_ready),
      .out_valid (fifo_out_valid),
      .out_data  (fifo_out_word),
      .out_ready (reg_ready),
      .flush     (1'b0)
   );

   always_comb begin
      nxt_st          = st_ff;
      nxt_st.scl_sync = {st_ff.scl_sync[0], link.scl};
      nxt_st.sda_sync = {st_ff.sda_sync[0], link.sda};
      nxt_st.scl_d    = scl_s;
      nxt_st.sda_d    = sda_s;
      nxt_st.wr_pulse = fifo_out_valid && reg_ready;
      // Word is held in flops so it stands beside the write pulse
      if (fifo_out_valid && reg_ready) begin
         {nxt_st.wr_addr, nxt_st.wr_data} = fifo_out_word;
      end
      if (st_ff.pend && fifo_in_ready) begin
         nxt_st.pend = 1'b0;
         nxt_st.ptr  = st_ff.ptr + 8'h01;
      end
      // Hold SCL low while a byte is still waiting for room
      nxt_st.scl_oe = st_ff.pend && !fifo_in_ready && !scl_s;
      if (start_det) begin
         nxt_st.busy    = 1'b1;
         nxt_st.state   = ST_ADDR;
         nxt_st.bit_idx = i2c_pkg::FIRST_BIT;
         nxt_st.sda_oe  = 1'b0;
         nxt_st.got8    = 1'b0;
      end else if (stop_det) begin
         nxt_st.busy    = 1'b0;
         nxt_st.state   = ST_IDLE;
         nxt_st.sda_oe  = 1'b0;
         nxt_st.got_ptr = 1'b0;
      end else begin
         if (scl_s && sda_s && st_ff.state == ST_IDLE) begin
            nxt_st.busy = 1'b0;
         end
         case (st_ff.state)
            ST_ADDR, ST_RX: begin
               if (scl_rise) begin
                  nxt_st.shreg = {st_ff.shreg[6:0], sda_s};
                  nxt_st.bit_idx = st_ff.bit_idx + 3'h1;
                  nxt_st.got8    = (st_ff.bit_idx == i2c_pkg::LAST_BIT);
               end
               // Only a fall after eight rises ends a byte, not the start's
               if (scl_fall && st_ff.got8) begin
                  nxt_st.got8 = 1'b0;
                  if (st_ff.state == ST_ADDR) begin
                     if (st_ff.shreg[7:1] == i2c_pkg::TARGET_ADDR) begin
                        nxt_st.reading = (st_ff.shreg[0] == i2c_pkg::RW_READ);
                        nxt_st.sda_oe  = 1'b1;
                        nxt_st.state   = ST_ACK_ADDR;
                     end else begin
                        nxt_st.state = ST_IGNORE;
                     end
                  end else if (!st_ff.pend) begin
                     nxt_st.sda_oe = 1'b1;
                     nxt_st.state  = ST_ACK_RX;
                     if (!st_ff.got_ptr) begin
                        nxt_st.ptr     = st_ff.shreg & i2c_pkg::PTR_MSB_MASK;
                        nxt_st.got_ptr = 1'b1;
                     end else begin
                        nxt_st.wdata = st_ff.shreg;
                        nxt_st.pend  = 1'b1;
                     end
                  end
               end
            end
            ST_ACK_ADDR, ST_ACK_RX: begin
               if (scl_fall) begin
                  nxt_st.sda_oe  = 1'b0;
                  nxt_st.bit_idx = i2c_pkg::FIRST_BIT;
                  if (st_ff.state == ST_ACK_ADDR && st_ff.reading) begin
                     nxt_st.shreg  = reg_rdata;
                     nxt_st.sda_oe = !reg_rdata[7];
                     nxt_st.state  = ST_TX;
                  end else begin
                     nxt_st.state = ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (st_ff.bit_idx == i2c_pkg::LAST_BIT) begin
                     nxt_st.sda_oe = 1'b0;
                     nxt_st.state  = ST_ACK_TX;
                     nxt_st.ptr    = st_ff.ptr + 8'h01;
                  end else begin
                     nxt_st.shreg   = {st_ff.shreg[6:0], 1'b0};
                     nxt_st.sda_oe  = !st_ff.shreg[6];
                     nxt_st.bit_idx = st_ff.bit_idx + 3'h1;
                  end
               end
            end
            ST_ACK_TX: begin
               if (scl_rise) begin
                  nxt_st.shreg = {7'h00, sda_s};
               end
               if (scl_fall) begin
                  nxt_st.bit_idx = i2c_pkg::FIRST_BIT;
                  if (st_ff.shreg[0]) begin
                     nxt_st.state = ST_IGNORE;
                  end else begin
                     nxt_st.shreg  = reg_rdata;
                     nxt_st.sda_oe = !reg_rdata[7];
                     nxt_st.state  = ST_TX;
                  end
               end
            end
            ST_IGNORE: begin
               nxt_st.sda_oe = 1'b0;
            end
            default: begin
               nxt_st.state = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff          <= '0;
         st_ff.scl_sync <= 2'h3;
         st_ff.sda_sync <= 2'h3;
         st_ff.scl_d    <= 1'b1;
         st_ff.sda_d    <= 1'b1;
         st_ff.state    <= ST_IDLE;
         st_ff.ptr      <= i2c_pkg::PTR_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Never drives SCL high or makes the clock; only stretches it
   assign link.scl_oe_dev = st_ff.scl_oe;
   assign link.sda_oe_dev = st_ff.sda_oe;
   assign reg_write       = st_ff.wr_pulse;
   assign reg_addr        = st_ff.wr_addr;
   assign reg_wdata       = st_ff.wr_data;
   assign bus_busy        = st_ff.busy;
endmodule : i2c_target_port

// file: core/i2c_host_port.sv
// Host end: bus master that writes or reads one register
`timescale 1ns/1ps
module i2c_host_port (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Link
   i2c_link_if.host        link,
   // Command
   input  wire logic       cmd_valid,
   input  wire logic       cmd_read,
   input  wire logic [6:0] cmd_ptr,
   input  wire logic [7:0] cmd_wdata,
   output      logic       cmd_ready,
   // Answer
   output      logic       rsp_valid,
   output      logic [7:0] rsp_rdata,
   output      logic       rsp_nack
);
   // Four phases make one clock period, so each phase is half a half
   localparam logic [7:0] QTR_CNT = 8'(i2c_pkg::HALF_CYC / 2)
                                    - i2c_pkg::CNT_ONE;

   typedef enum logic [2:0] {
      H_IDLE, H_START, H_BYTE, H_ACK, H_RSTART, H_STOP, H_DONE
   } host_state_t;

   typedef struct packed {
      logic [1:0]  scl_sync;
      logic [1:0]  sda_sync;
      host_state_t state;
      logic [7:0]  cnt;
      logic [1:0]  phase;
      logic [2:0]  bit_idx;
      logic [2:0]  step;
      logic [7:0]  shreg;
      logic        rd;
      logic [6:0]  ptr;
      logic [7:0]  wdata;
      logic        scl_oe;
      logic        sda_oe;
      logic        nack;
      logic        rvalid;
      logic [7:0]  rdata;
   } host_st_t;

   host_st_t st_ff;
   host_st_t nxt_st;
   logic     tick;
   logic     scl_s;
   logic     sda_s;
   logic     rx_byte;

   assign scl_s   = st_ff.scl_sync[1];
   assign sda_s   = st_ff.sda_sync[1];
   assign tick    = (st_ff.cnt == i2c_pkg::CNT_ZERO);
   // Step 0 addr+W, 1 pointer, 2 data or addr+R, 3 read data
   assign rx_byte = (st_ff.step == 3'h3);

   always_comb begin
      nxt_st          = st_ff;
      nxt_st.scl_sync = {st_ff.scl_sync[0], link.scl};
      nxt_st.sda_sync = {st_ff.sda_sync[0], link.sda};
      nxt_st.rvalid   = 1'b0;
      nxt_st.cnt      = tick ? QTR_CNT : st_ff.cnt - i2c_pkg::CNT_ONE;
      // Quarter-phase sequencer; a held-low SCL freezes it
      if (tick && !(st_ff.scl_oe == 1'b0 && !scl_s)) begin
         nxt_st.phase = st_ff.phase + 2'h1;
         case (st_ff.state)
            H_IDLE: begin
               nxt_st.phase = 2'h0;
               if (cmd_valid && scl_s && sda_s) begin
                  nxt_st.rd    = cmd_read;
                  nxt_st.ptr   = cmd_ptr;
                  nxt_st.wdata = cmd_wdata;
                  nxt_st.step  = 3'h0;
                  nxt_st.nack  = 1'b0;
                  nxt_st.state = H_START;
               end
            end
            H_START, H_RSTART: begin
               if (st_ff.phase == 2'h0) nxt_st.scl_oe = 1'b0;
               if (st_ff.phase == 2'h1) nxt_st.sda_oe = 1'b1;
               if (st_ff.phase == 2'h3) begin
                  nxt_st.scl_oe  = 1'b1;
                  nxt_st.shreg   = {i2c_pkg::TARGET_ADDR,
                                    st_ff.state == H_RSTART};
                  nxt_st.bit_idx = i2c_pkg::FIRST_BIT;
                  nxt_st.state   = H_BYTE;
               end
            end
            H_BYTE, H_ACK: begin
               if (st_ff.phase == 2'h0) begin
                  if (st_ff.state == H_BYTE) begin
                     nxt_st.sda_oe = rx_byte ? 1'b0 : !st_ff.shreg[7];
                  end else begin
                     // Released: target acks, or the single read is nacked
                     nxt_st.sda_oe = 1'b0;
                  end
               end
               if (st_ff.phase == 2'h1) nxt_st.scl_oe = 1'b0;
               if (st_ff.phase == 2'h2 && st_ff.state == H_BYTE) begin
                  nxt_st.shreg = {st_ff.shreg[6:0], sda_s};
               end
               if (st_ff.phase == 2'h2 && st_ff.state == H_ACK
                   && !rx_byte && sda_s) begin
                  nxt_st.nack = 1'b1;
               end
               if (st_ff.phase == 2'h3) begin
                  nxt_st.scl_oe = 1'b1;
                  if (st_ff.state == H_BYTE) begin
                     nxt_st.bit_idx = st_ff.bit_idx + 3'h1;
                     if (st_ff.bit_idx == i2c_pkg::LAST_BIT) begin
                        nxt_st.state = H_ACK;
                        if (rx_byte) nxt_st.rdata = st_ff.shreg;
                     end
                  end else if (st_ff.nack || rx_byte) begin
                     nxt_st.state = H_STOP;
                  end else begin
                     nxt_st.step    = st_ff.step + 3'h1;
                     nxt_st.bit_idx = i2c_pkg::FIRST_BIT;
                     nxt_st.state   = H_BYTE;
                     if (st_ff.step == 3'h0) begin
                        nxt_st.shreg = {1'b0, st_ff.ptr};
                     end else if (st_ff.step == 3'h1 && st_ff.rd) begin
                        nxt_st.state = H_RSTART;
                     end else if (st_ff.step == 3'h1) begin
                        nxt_st.shreg = st_ff.wdata;
                     end else if (st_ff.step == 3'h2 && !st_ff.rd) begin
                        nxt_st.state = H_STOP;
                     end
                  end
               end
            end
            H_STOP: begin
               if (st_ff.phase == 2'h0) nxt_st.sda_oe = 1'b1;
               if (st_ff.phase == 2'h1) nxt_st.scl_oe = 1'b0;
               if (st_ff.phase == 2'h3) begin
                  nxt_st.sda_oe = 1'b0;
                  nxt_st.state  = H_DONE;
               end
            end
            default: begin
               nxt_st.rvalid = 1'b1;
               nxt_st.state  = H_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff          <= '0;
         st_ff.scl_sync <= 2'h3;
         st_ff.sda_sync <= 2'h3;
         st_ff.state    <= H_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign link.scl_oe_host = st_ff.scl_oe;
   assign link.sda_oe_host = st_ff.sda_oe;
   assign cmd_ready        = (st_ff.state == H_IDLE) && tick && scl_s && sda_s;
   assign rsp_valid        = st_ff.rvalid;
   assign rsp_rdata        = st_ff.rdata;
   assign rsp_nack         = st_ff.nack;
endmodule : i2c_host_port

// file: verification/i2c_link_sva.sv
// Protocol checks on the two-wire link between host and target ends
`timescale 1ns/1ps
module i2c_link_sva (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Wired lines
   input wire logic scl,
   input wire logic sda,
   // Pull-down enables
   input wire logic scl_oe_host,
   input wire logic sda_oe_host,
   input wire logic scl_oe_dev,
   input wire logic sda_oe_dev
);
   logic       scl_q_ff;
   logic       sda_q_ff;
   logic [3:0] cnt_ff;
   logic [7:0] sh_ff;
   logic       first_ff;
   logic       rw_ff;
   logic       match_ff;
   logic       nack_ff;
   logic       rise;
   logic       start_c;
   logic       stop_c;

   assign rise    = scl && !scl_q_ff;
   assign start_c = scl && scl_q_ff && sda_q_ff && !sda;
   assign stop_c  = scl && scl_q_ff && !sda_q_ff && sda;

   // Bit position within the byte, counted on clock line rises
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
         cnt_ff   <= 4'h0;
         sh_ff    <= 8'h00;
         first_ff <= 1'b0;
         rw_ff    <= 1'b0;
         match_ff <= 1'b0;
         nack_ff  <= 1'b0;
      end else begin
         scl_q_ff <= scl;
         sda_q_ff <= sda;
         if (start_c || stop_c) begin
            cnt_ff   <= 4'h0;
            first_ff <= start_c;
            nack_ff  <= 1'b0;
         end else if (rise) begin
            sh_ff <= {sh_ff[6:0], sda};
            if (cnt_ff == 4'h7 && first_ff) begin
               rw_ff <= sda;
            end
            if (cnt_ff == 4'h8) begin
               cnt_ff   <= 4'h0;
               first_ff <= 1'b0;
               // Host nack ends the read; the stop follows
               if (!first_ff && rw_ff) begin
                  nack_ff <= sda;
               end
               if (first_ff) begin
                  match_ff <= (sh_ff[7:1] == i2c_pkg::TARGET_ADDR);
               end
            end else begin
               cnt_ff <= cnt_ff + 4'h1;
            end
         end
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_start;
      start_c;
   endsequence
   sequence s_stop;
      stop_c;
   endsequence
   sequence s_ack_slot;
      rise && cnt_ff == 4'h8;
   endsequence
   sequence s_last_addr_bit;
      rise && cnt_ff == 4'h7 && first_ff;
   endsequence

   chk_stretch_low:
      assert property ($rose(scl_oe_dev) |-> !$past(scl))
      else $error("target pulled the clock line while it was high");
   chk_sda_hold_high:
      assert property (scl && $past(scl) |-> $stable(sda_oe_dev))
      else $error("target changed the data line while clock was high");
   chk_stop_release:
      assert property (s_stop |=> (!sda_oe_dev && !scl_oe_dev) [*8])
      else $error("target still driving after a stop");
   chk_start_quiet:
      assert property (s_start |=> !sda_oe_dev [*8])
      else $error("target drove data right after a start");
   chk_addr_bits:
      assert property (s_last_addr_bit |-> sh_ff[6:0] == i2c_pkg::TARGET_ADDR)
      else $error("address bits on the wire differ from the target");
   chk_addr_ack:
      assert property (s_ack_slot ##0 (first_ff &&
                       sh_ff[7:1] == i2c_pkg::TARGET_ADDR) |-> sda_oe_dev)
      else $error("matching address not acknowledged");
   chk_write_ack:
      assert property (s_ack_slot ##0 (!first_ff && !rw_ff && match_ff)
                       |-> sda_oe_dev)
      else $error("written byte not acknowledged");
   chk_read_release:
      assert property (s_ack_slot ##0 (!first_ff && rw_ff) |-> !sda_oe_dev)
      else $error("target held data line in the host acknowledge slot");
   chk_read_host_off:
      assert property (rise && cnt_ff < 4'h8 && !first_ff && rw_ff &&
                       match_ff && !nack_ff |-> !sda_oe_host)
      else $error("host drove data line while target was sending");
endmodule : i2c_link_sva

// file: verification/i2c_register_target_port_test.sv
// Bench joining host and target ends with register side and wire monitor
`timescale 1ns/1ps
module i2c_register_target_port_test;
   logic        clk;
   logic        reset_n;
   logic        cmd_valid;
   logic        cmd_read;
   logic [6:0]  cmd_ptr;
   logic [7:0]  cmd_wdata;
   logic        cmd_ready;
   logic        rsp_valid;
   logic [7:0]  rsp_rdata;
   logic        rsp_nack;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_write;
   logic [7:0]  reg_rdata;
   logic        reg_ready;
   logic        bus_busy;
   logic        stall;
   logic [6:0]  rd_ptr;
   logic [7:0]  mem [128];
   logic [7:0]  exp_mem [128];
   logic [15:0] exp_wr [$];
   logic [7:0]  wire_q [$];
   logic [3:0]  bit_cnt = 4'h0;
   logic [7:0]  shreg   = 8'h00;
   logic        scl_q   = 1'b1;
   logic        sda_q   = 1'b1;
   int          n_fail;
   int          compares;

   i2c_link_if i2c_link_if_inst ();

   i2c_target_port i2c_target_port_inst (
      .clk(clk), .reset_n(reset_n), .link(i2c_link_if_inst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_rdata(reg_rdata), .reg_ready(reg_ready), .bus_busy(bus_busy));

   i2c_host_port i2c_host_port_inst (
      .clk(clk), .reset_n(reset_n), .link(i2c_link_if_inst),
      .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_ptr(cmd_ptr),
      .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack));

   i2c_link_sva i2c_link_sva_inst (
      .clk(clk), .reset_n(reset_n),
      .scl(i2c_link_if_inst.scl), .sda(i2c_link_if_inst.sda),
      .scl_oe_host(i2c_link_if_inst.scl_oe_host),
      .sda_oe_host(i2c_link_if_inst.sda_oe_host),
      .scl_oe_dev(i2c_link_if_inst.scl_oe_dev),
      .sda_oe_dev(i2c_link_if_inst.sda_oe_dev));

   task automatic check(input logic [15:0] seen, input logic [15:0] expd);
      compares++;
      if (seen !== expd) begin
         n_fail++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, expd);
      end
   endtask : check

   task automatic report_and_stop();
      if (n_fail == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop

   // One host command, then the wire bytes and the answer are compared
   task automatic do_cmd(input logic rd, input logic [6:0] ptr,
                         input logic [7:0] wd);
      int n;
      wire_q.delete();
      rd_ptr    <= ptr;
      cmd_valid <= 1'b1;
      cmd_read  <= rd;
      cmd_ptr   <= ptr;
      cmd_wdata <= wd;
      if (!rd) begin
         exp_wr.push_back({1'b0, ptr, wd});
         exp_mem[ptr] = wd;
      end
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 1000);
      check(16'(cmd_ready), 16'h0001);
      cmd_valid <= 1'b0;
      n = 0;
      while (wire_q.size() == 0 && n < 4000) begin
         @(posedge clk);
         n++;
      end
      check(16'(bus_busy), 16'h0001);
      n = 0;
      while (rsp_valid !== 1'b1 && n < 20000) begin
         @(posedge clk);
         n++;
      end
      check(16'(rsp_valid), 16'h0001);
      check(16'(rsp_nack), 16'h0000);
      check(16'(wire_q.size()), rd ? 16'h0004 : 16'h0003);
      check(16'(wire_q[0]), {8'h00, i2c_pkg::TARGET_ADDR, 1'b0});
      check(16'(wire_q[1]), {9'h000, ptr});
      if (rd) begin
         check(16'(wire_q[2]), {8'h00, i2c_pkg::TARGET_ADDR, 1'b1});
         check(16'(wire_q[3]), {8'h00, exp_mem[ptr]});
         check(16'(rsp_rdata), {8'h00, exp_mem[ptr]});
      end else begin
         check(16'(wire_q[2]), {8'h00, wd});
      end
      repeat (3) @(posedge clk);
      check(16'(bus_busy), 16'h0000);
   endtask : do_cmd

   // Register side and wire byte monitor
   always @(posedge clk) begin
      reg_ready <= stall ? 1'b0 : ($urandom_range(3) != 0);
      reg_rdata <= mem[rd_ptr];
      if (reg_write === 1'b1) begin
         check({reg_addr, reg_wdata},
               exp_wr.size() > 0 ? exp_wr.pop_front() : 16'hFFFF);
         mem[reg_addr[6:0]] <= reg_wdata;
      end
      scl_q <= i2c_link_if_inst.scl;
      sda_q <= i2c_link_if_inst.sda;
      if (i2c_link_if_inst.scl && scl_q && sda_q && !i2c_link_if_inst.sda) begin
         bit_cnt <= 4'h0;
      end else if (i2c_link_if_inst.scl && !scl_q) begin
         bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
         shreg   <= {shreg[6:0], i2c_link_if_inst.sda};
         if (bit_cnt == 4'h7) begin
            wire_q.push_back({shreg[6:0], i2c_link_if_inst.sda});
         end
      end
   end

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      repeat (100_000) @(posedge clk);
      n_fail++;
      report_and_stop();
   end

   initial begin
      reset_n   = 1'b0;
      cmd_valid = 1'b0;
      cmd_read  = 1'b0;
      cmd_ptr   = 7'h00;
      cmd_wdata = 8'h00;
      reg_rdata = 8'h00;
      reg_ready = 1'b1;
      stall     = 1'b0;
      rd_ptr    = 7'h00;
      n_fail    = 0;
      compares  = 0;
      void'($urandom(69));
      for (int i = 0; i < 128; i++) begin
         mem[i]     = 8'($urandom);
         exp_mem[i] = mem[i];
      end
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      do_cmd(1'b0, 7'h7F, 8'h00);
      // Register side stalls: four words fill the FIFO, the fifth stretches
      stall <= 1'b1;
      do_cmd(1'b0, 7'h00, 8'hFF);
      for (int i = 0; i < 3; i++) begin
         do_cmd(1'b0, 7'($urandom), 8'($urandom));
      end
      check(16'(exp_wr.size()), 16'h0004);
      fork
         do_cmd(1'b0, 7'($urandom), 8'($urandom));
         begin : release_stall
            int n;
            n = 0;
            while (i2c_link_if_inst.scl_oe_dev !== 1'b1 && n < 20000) begin
               @(posedge clk);
               n++;
            end
            check(16'(i2c_link_if_inst.scl_oe_dev), 16'h0001);
            repeat (500) @(posedge clk);
            stall <= 1'b0;
         end
      join
      repeat (20) @(posedge clk);
      check(16'(exp_wr.size()), 16'h0000);
      do_cmd(1'b1, 7'h7F, 8'h00);
      do_cmd(1'b1, 7'h00, 8'h00);
      do_cmd(1'b1, 7'($urandom), 8'h00);
      report_and_stop();
   end
endmodule : i2c_register_target_port_test
